// >>> inc/ssim_pkg.sv
package ssim_pkg;
  localparam int SSIM_NUM_SRC = 12;
  localparam logic [11:0] SSIM_ADDR_STATUS = 12'h040;
  localparam logic [11:0] SSIM_ADDR_SET = 12'h044;
  localparam logic [11:0] SSIM_ADDR_CLR = 12'h048;
  localparam logic [11:0] SSIM_ADDR_MASK = 12'h04C;
  localparam logic [11:0] SSIM_MASK_RESET = 12'h000;
  localparam int SSIM_BIT_TX_HOLDING_FREE = 0;
  localparam int SSIM_BIT_TX_FULLY_IDLE = 1;
  localparam int SSIM_BIT_TX_COUNT_DONE = 2;
  localparam int SSIM_BIT_TX_BUFFERS_DRAINED = 3;
  localparam int SSIM_BIT_RX_WORD_AVAILABLE = 4;
  localparam int SSIM_BIT_RX_OVERRUN_FLAG = 5;
  localparam int SSIM_BIT_RX_COUNT_DONE = 6;
  localparam int SSIM_BIT_RX_BUFFERS_FILLED = 7;
  localparam int SSIM_BIT_COMPARE_MATCH_ZERO = 8;
  localparam int SSIM_BIT_COMPARE_MATCH_ONE = 9;
  localparam int SSIM_BIT_TX_FRAME_SYNC_SEEN = 10;
  localparam int SSIM_BIT_RX_FRAME_SYNC_SEEN = 11;

  typedef struct packed {
    logic tx_holding_free;
    logic tx_shift_busy;
    logic tx_count_done;
    logic tx_buffers_drained;
    logic rx_word_load;
    logic rx_word_read;
    logic rx_count_done;
    logic rx_buffers_filled;
    logic compare_match_zero;
    logic compare_match_one;
    logic tx_frame_sync;
    logic rx_frame_sync;
  } ssim_evt_t;

  typedef struct packed {
    logic [11:0] sticky;
    logic rx_full;
  } ssim_flag_t;

  typedef struct packed {
    logic [11:0] mask;
    logic [31:0] prdata;
  } ssim_state_t;
endpackage

// >>> hdl/ssim_flags.sv
`timescale 1ns/1ps
module ssim_flags
  import ssim_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // controller events
  input wire ssim_pkg::ssim_evt_t evt,
  input wire logic status_read,
  // flags
  output logic [11:0] status
);
  import ssim_pkg::*;

  ssim_flag_t st;
  ssim_flag_t next_st;

  always_comb
  begin
    next_st = st;
    if (status_read)
    begin
      next_st.sticky = '0;
    end
    // overrun on load while full
    // overrun detect, set wins
    if (evt.rx_word_load && st.rx_full && !evt.rx_word_read)
    begin
      next_st.sticky[SSIM_BIT_RX_OVERRUN_FLAG] = 1'b1;
    end
    if (evt.rx_word_read)
    begin
      next_st.rx_full = 1'b0;
    end
    if (evt.rx_word_load)
    begin
      next_st.rx_full = 1'b1;
    end
    if (evt.compare_match_zero)
    begin
      next_st.sticky[SSIM_BIT_COMPARE_MATCH_ZERO] = 1'b1;
    end
    if (evt.compare_match_one)
    begin
      next_st.sticky[SSIM_BIT_COMPARE_MATCH_ONE] = 1'b1;
    end
    if (evt.tx_frame_sync)
    begin
      next_st.sticky[SSIM_BIT_TX_FRAME_SYNC_SEEN] = 1'b1;
    end
    if (evt.rx_frame_sync)
    begin
      next_st.sticky[SSIM_BIT_RX_FRAME_SYNC_SEEN] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_comb
  begin
    status = st.sticky;
    status[SSIM_BIT_TX_HOLDING_FREE] = evt.tx_holding_free;
    // idle only when holding and shifter empty
    status[SSIM_BIT_TX_FULLY_IDLE] = evt.tx_holding_free && !evt.tx_shift_busy;
    status[SSIM_BIT_TX_COUNT_DONE] = evt.tx_count_done;
    status[SSIM_BIT_TX_BUFFERS_DRAINED] = evt.tx_buffers_drained;
    status[SSIM_BIT_RX_WORD_AVAILABLE] = st.rx_full;
    status[SSIM_BIT_RX_COUNT_DONE] = evt.rx_count_done;
    status[SSIM_BIT_RX_BUFFERS_FILLED] = evt.rx_buffers_filled;
  end

  overrun_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    evt.rx_word_load && st.rx_full && !evt.rx_word_read |=> status[SSIM_BIT_RX_OVERRUN_FLAG])
    else $error("overrun not set");
  sync_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    status[SSIM_BIT_TX_FRAME_SYNC_SEEN] && !status_read |=> status[SSIM_BIT_TX_FRAME_SYNC_SEEN])
    else $error("frame sync flag dropped");
  compare_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    evt.compare_match_zero |=> status[SSIM_BIT_COMPARE_MATCH_ZERO])
    else $error("compare flag not set");
  tx_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    evt.tx_shift_busy |-> !status[SSIM_BIT_TX_FULLY_IDLE])
    else $error("idle while shifting");
endmodule

// >>> hdl/ssim_top.sv
`timescale 1ns/1ps
module ssim_top
  import ssim_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial controller events
  input wire ssim_pkg::ssim_evt_t evt,
  // interrupt line
  output logic irq
);
  import ssim_pkg::*;

  ssim_state_t st;
  ssim_state_t next_st;
  logic [11:0] status;
  logic access;
  logic wr;
  logic rd;
  logic setup_rd;
  logic status_read;
  logic known;

  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign pready = 1'b1;
  assign known = (paddr == SSIM_ADDR_STATUS) || (paddr == SSIM_ADDR_SET)
    || (paddr == SSIM_ADDR_CLR) || (paddr == SSIM_ADDR_MASK);
  assign pslverr = access && !known;
  assign setup_rd = psel && !penable && !pwrite;
  // capture and clear meet at the setup edge, so an event in that cycle survives for the next read
  assign status_read = setup_rd && (paddr == SSIM_ADDR_STATUS);

  ssim_flags u_flags (
    .pclk(pclk),
    .presetn(presetn),
    .evt(evt),
    .status_read(status_read),
    .status(status)
  );

  always_comb
  begin
    next_st = st;
    if (wr && paddr == SSIM_ADDR_SET)
    begin
      next_st.mask = st.mask | pwdata[11:0];
    end
    else if (wr && paddr == SSIM_ADDR_CLR)
    begin
      next_st.mask = st.mask & ~pwdata[11:0];
    end
    if (setup_rd)
    begin
      if (paddr == SSIM_ADDR_STATUS)
      begin
        next_st.prdata = {20'h0_0000, status};
      end
      else if (paddr == SSIM_ADDR_MASK)
      begin
        next_st.prdata = {20'h0_0000, st.mask};
      end
      else
      begin
        next_st.prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '{mask: SSIM_MASK_RESET, prdata: 32'h0000_0000};
    end
    else
    begin
      st <= next_st;
    end
  end

  // read data registered from the setup phase so it is valid in the access cycle
  assign prdata = st.prdata;

  assign irq = |(status & st.mask);

  mask_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == SSIM_ADDR_SET |=> (st.mask & $past(pwdata[11:0])) == $past(pwdata[11:0]))
    else $error("set write missed");
  mask_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == SSIM_ADDR_CLR |=> (st.mask & $past(pwdata[11:0])) == 12'h000)
    else $error("clear write missed");
  mask_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    !wr |=> st.mask == $past(st.mask))
    else $error("mask changed without write");
  mask_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == SSIM_ADDR_MASK |-> prdata == {20'h0_0000, st.mask})
    else $error("mask readback wrong");
  status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    status_read |=> prdata == {20'h0_0000, $past(status)})
    else $error("status readback wrong");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == ((status & st.mask) != 12'h000))
    else $error("irq mismatch");
endmodule

// >>> testbench/ssim_evt_src.sv
`timescale 1ns/1ps
module ssim_evt_src
(
  // clock
  input wire logic pclk,
  // requested status bits and rx word read
  input wire logic [11:0] want,
  input wire logic rd,
  // events toward the block
  output ssim_pkg::ssim_evt_t evt
);
  import ssim_pkg::*;
  logic [11:0] p1;
  logic [11:0] p2;
  always_ff @(posedge pclk)
  begin
    p1 <= want;
    p2 <= p1;
  end
  // levels follow the request, pulses fire on its rise
  // overrun request makes two loads back to back
  always_comb
  begin
    evt = '0;
    evt.tx_holding_free = want[0] | want[1];
    evt.tx_shift_busy = want[0];
    evt.tx_count_done = want[2];
    evt.tx_buffers_drained = want[3];
    evt.rx_word_load = (want[4] & ~p1[4]) | (want[5] & ~p2[5]);
    evt.rx_word_read = rd;
    evt.rx_count_done = want[6];
    evt.rx_buffers_filled = want[7];
    evt.compare_match_zero = want[8] & ~p1[8];
    evt.compare_match_one = want[9] & ~p1[9];
    evt.tx_frame_sync = want[10] & ~p1[10];
    evt.rx_frame_sync = want[11] & ~p1[11];
  end
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ssim_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic err;
  logic [31:0] r;
  logic [31:0] e;
  logic [11:0] want;
  logic rd;
  ssim_evt_t evt;
  int bad_count;
  int checks;
  int wt;

  ssim_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .evt(evt), .irq(irq));
  ssim_evt_src i_src (.pclk(pclk), .want(want), .rd(rd), .evt(evt));

  always #2 pclk = ~pclk;

  task automatic stop_test();
    if (bad_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] got);
    checks++;
    if (got !== x)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
      n++;
    end
    wt = n;
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    stop_test();
  end

  initial
  begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    want = '0;
    rd = 0;
    bad_count = 0;
    checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, SSIM_ADDR_MASK, '0);
    chk("mask reset", '0, r);
    chk("wait states", '0, wt);
    apb(1, SSIM_ADDR_SET, 32'hFFFF_F0A5);
    apb(1, SSIM_ADDR_SET, 32'h0000_0F00);
    apb(0, SSIM_ADDR_MASK, '0);
    chk("mask set", 32'h0000_0FA5, r);
    apb(1, SSIM_ADDR_CLR, 32'hFFFF_F005);
    apb(0, SSIM_ADDR_MASK, '0);
    chk("mask clear", 32'h0000_0FA0, r);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, SSIM_ADDR_MASK, '0);
    chk("mask after reset", '0, r);
    apb(0, 12'h050, '0);
    chk("unmapped", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", '0, r);
    for (int i = 0; i < 12; i++)
    begin
      e = (32'h0000_0001 << i) | ((i == 1) ? 32'h0000_0001 : '0) | ((i == 5) ? 32'h0000_0010 : '0);
      apb(1, SSIM_ADDR_CLR, 32'h0000_0FFF);
      apb(1, SSIM_ADDR_SET, 32'h0000_0001 << i);
      apb(0, SSIM_ADDR_MASK, '0);
      chk("mask bit", 32'h0000_0001 << i, r);
      chk("irq idle", '0, {31'h0, irq});
      want <= 12'h001 << i;
      repeat (5) @(posedge pclk);
      chk("irq raised", 32'h0000_0001, {31'h0, irq});
      apb(1, SSIM_ADDR_CLR, 32'h0000_0001 << i);
      @(posedge pclk);
      chk("irq masked", '0, {31'h0, irq});
      apb(0, SSIM_ADDR_STATUS, '0);
      chk("status", e, r);
      want <= '0;
      rd <= 1'b1;
      @(posedge pclk);
      rd <= 1'b0;
      apb(0, SSIM_ADDR_STATUS, '0);
      chk("status cleared", '0, r);
    end
    stop_test();
  end
endmodule
